/* inc/mdsl_pkg.sv */
// Package: constants and carriers for the motor driver SPI slave link
package mdsl_pkg;
  localparam int MDSL_WORD_BITS = 16;
  localparam int MDSL_MAX_DATA_WORDS = 32;
  localparam logic [7:0] MDSL_CMD_LINK_CHECK = 8'h00;
  localparam logic [7:0] MDSL_CMD_WRITE = 8'h02;
  localparam logic [7:0] MDSL_CMD_READ = 8'h03;
  localparam logic [7:0] MDSL_CMD_ACTIVATE = 8'h08;
  localparam logic [7:0] MDSL_CMD_DEACTIVATE = 8'h09;
  localparam logic [7:0] MDSL_ADDR_STEP = 8'h02;
  localparam logic [15:0] MDSL_RESERVED_HEADER_WORD = 16'h0000;
  localparam int MDSL_CLK_HZ = 10_000_000;
  localparam int MDSL_FRAME_GAP_US = 1000;
  localparam int MDSL_FRAME_GAP_CYC = (MDSL_CLK_HZ / 1_000_000) * MDSL_FRAME_GAP_US;

  // Pins of the serial link as seen by the device
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic mosi;
  } mdsl_pin_in_s;

  typedef struct packed {
    logic miso_out;
    logic miso_oe;
  } mdsl_pin_out_s;

  // Register access request towards the setting registers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } mdsl_reg_req_s;

  typedef enum logic [4:0] {
    MDSL_ST_IDLE = 5'b00001,
    MDSL_ST_HDR0 = 5'b00010,
    MDSL_ST_HDR1 = 5'b00100,
    MDSL_ST_DATA = 5'b01000,
    MDSL_ST_SKIP = 5'b10000
  } mdsl_state_e;
endpackage : mdsl_pkg

/* logic/mdsl_sync.sv */
// Two flip-flop synchroniser for the link pins
`timescale 1ns/1ps
module mdsl_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be positive");
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q_sync <= RESET_VAL;
    end else begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
    end
  end
endmodule : mdsl_sync

/* logic/mdsl_link.sv */
// Motor driver SPI slave link: mode 3 framing and command decode
`timescale 1ns/1ps
module mdsl_link
  import mdsl_pkg::*;
#(
  parameter int MAX_WORDS = MDSL_MAX_DATA_WORDS
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link pins
  input wire logic spi_sel_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe,
  // Setting register port
  output mdsl_reg_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  // Driver status words
  input wire logic [15:0] status0,
  input wire logic [15:0] status1,
  // Driver state
  output logic operating,
  output logic frame_error
);
  // Word counter and eight-bit address cannot serve longer fields
  if (MAX_WORDS < 1 || MAX_WORDS > 255) begin : g_bad_max_words
    $error("MAX_WORDS out of range");
  end

  mdsl_pin_in_s pin_raw;
  mdsl_pin_in_s pin_s;
  mdsl_pin_out_s pout;
  logic sck_d_reg;
  logic sel_d_reg;
  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  logic selected;
  logic [3:0] bit_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_word;
  logic word_done;
  mdsl_state_e state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;
  logic [8:0] words_reg;
  logic miso_reg;
  logic tx_pending_reg;

  assign pin_raw = '{sel_n: spi_sel_n, sck: spi_sck, mosi: spi_mosi};

  mdsl_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d_async(pin_raw),
    .q_sync(pin_s)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_d_reg <= 1'b1;
      sel_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= pin_s.sck;
      sel_d_reg <= pin_s.sel_n;
    end
  end

  assign selected = !pin_s.sel_n;
  // Edges count only while selected, so idle bus chatter is dropped
  assign sck_rise = selected && pin_s.sck && !sck_d_reg;
  assign sck_fall = selected && !pin_s.sck && sck_d_reg;
  assign sel_fall = !pin_s.sel_n && sel_d_reg;
  assign rx_word = {rx_reg[14:0], pin_s.mosi};
  assign word_done = sck_rise && (bit_reg == 4'hF);

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == MDSL_CMD_WRITE) || (c == MDSL_CMD_READ) || (c == MDSL_CMD_ACTIVATE) ||
                (c == MDSL_CMD_DEACTIVATE) || (c == MDSL_CMD_LINK_CHECK);
  endfunction : known_cmd

  // Bit counter and receive shifter
  always_ff @(posedge clk_sys) begin
    if (rst || sel_fall) begin
      bit_reg <= 4'h0;
      rx_reg <= 16'h0000;
    end else if (sck_rise) begin
      bit_reg <= bit_reg + 4'h1;
      rx_reg <= rx_word;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= MDSL_ST_IDLE;
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
      words_reg <= 9'h000;
      frame_error <= 1'b0;
    end else if (sel_fall) begin
      state_reg <= MDSL_ST_HDR0;
      words_reg <= 9'h000;
      frame_error <= 1'b0;
    end else if (!selected) begin
      state_reg <= MDSL_ST_IDLE;
    end else if (word_done) begin
      case (state_reg)
        MDSL_ST_HDR0: begin
          cmd_reg <= rx_word[15:8];
          addr_reg <= {rx_word[7:1], 1'b0};
          state_reg <= MDSL_ST_HDR1;
        end
        MDSL_ST_HDR1: begin
          state_reg <= known_cmd(cmd_reg) ? MDSL_ST_DATA : MDSL_ST_SKIP;
        end
        MDSL_ST_DATA: begin
          words_reg <= words_reg + 9'h001;
          if (words_reg < 9'(MAX_WORDS)) begin
            addr_reg <= addr_reg + MDSL_ADDR_STEP;
          end else begin
            // Overlong data fields are dropped and flagged
            frame_error <= 1'b1;
          end
        end
        MDSL_ST_SKIP: begin
          state_reg <= MDSL_ST_SKIP;
        end
        default: begin
          state_reg <= MDSL_ST_IDLE;
        end
      endcase
    end
  end

  // Operation state, changed once the header is complete
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      operating <= 1'b0;
    end else if (word_done && state_reg == MDSL_ST_HDR1) begin
      if (cmd_reg == MDSL_CMD_ACTIVATE) begin
        operating <= 1'b1;
      end else if (cmd_reg == MDSL_CMD_DEACTIVATE) begin
        operating <= 1'b0;
      end
    end
  end

  // Register requests: write after each of the first MAX_WORDS data words, read ahead of it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_req <= '0;
    end else begin
      reg_req.wr <= 1'b0;
      reg_req.rd <= 1'b0;
      if (word_done && state_reg == MDSL_ST_DATA && words_reg < 9'(MAX_WORDS) &&
          cmd_reg == MDSL_CMD_WRITE) begin
        reg_req.wr <= 1'b1;
        reg_req.addr <= addr_reg;
        reg_req.data <= rx_word;
      end else if (word_done && cmd_reg == MDSL_CMD_READ &&
                   (state_reg == MDSL_ST_HDR1 || state_reg == MDSL_ST_DATA)) begin
        reg_req.rd <= 1'b1;
        reg_req.addr <= (state_reg == MDSL_ST_HDR1) ? addr_reg : addr_reg + MDSL_ADDR_STEP;
      end
    end
  end

  // Transmit shifter; read data lands one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_reg <= 16'h0000;
      miso_reg <= 1'b1;
      tx_pending_reg <= 1'b0;
    end else if (sel_fall) begin
      // First falling edge shifts bit 15 out again, as for every later word
      tx_reg <= status0;
      miso_reg <= status0[15];
      tx_pending_reg <= 1'b0;
    end else begin
      tx_pending_reg <= reg_req.rd;
      if (word_done && state_reg == MDSL_ST_HDR0) begin
        tx_reg <= status1;
      end else if (word_done) begin
        tx_reg <= 16'h0000;
      end else if (tx_pending_reg) begin
        tx_reg <= reg_rdata;
      end else if (sck_fall) begin
        miso_reg <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // Push-pull while selected, released otherwise for a shared line
  assign pout = '{miso_out: miso_reg, miso_oe: selected};
  assign spi_miso_out = pout.miso_out;
  assign spi_miso_oe = pout.miso_oe;
endmodule : mdsl_link

/* verification/mdsl_link_asserts.sv */
// Port checks for the link
`timescale 1ns/1ps
module mdsl_link_asserts
  import mdsl_pkg::*;
#(parameter int MAX_WORDS = 32) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_sel_n,
  input wire logic spi_miso_oe,
  input wire mdsl_reg_req_s reg_req,
  input wire logic operating
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] last_reg;
  logic seen_reg;
  // Forget the address between frames
  always_ff @(posedge clk_sys) seen_reg <= !(rst || spi_sel_n) && (seen_reg || reg_req.wr || reg_req.rd);
  always_ff @(posedge clk_sys) if (reg_req.wr || reg_req.rd) last_reg <= reg_req.addr;
  property p_oe_off; spi_sel_n [*4] |-> !spi_miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe high");
  property p_oe_on; !spi_sel_n [*4] |-> spi_miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe low");
  property p_wr; reg_req.wr |=> !reg_req.wr; endproperty
  a_wr: assert property (p_wr) else $error("wr pulse");
  property p_rd; reg_req.rd |=> !reg_req.rd && !reg_req.wr; endproperty
  a_rd: assert property (p_rd) else $error("rd pulse");
  property p_idle; spi_sel_n [*6] |-> !reg_req.wr && !reg_req.rd; endproperty
  a_idle: assert property (p_idle) else $error("idle req");
  property p_even; reg_req.wr || reg_req.rd |-> !reg_req.addr[0]; endproperty
  a_even: assert property (p_even) else $error("odd addr");
  property p_step; (reg_req.wr || reg_req.rd) && seen_reg |-> reg_req.addr == 8'(last_reg + 8'h02); endproperty
  a_step: assert property (p_step) else $error("addr step");
  property p_op; !$stable(operating) |-> !spi_sel_n; endproperty
  a_op: assert property (p_op) else $error("op change");
endmodule : mdsl_link_asserts
bind mdsl_link mdsl_link_asserts #(.MAX_WORDS(MAX_WORDS)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .spi_sel_n(spi_sel_n), .spi_miso_oe(spi_miso_oe), .reg_req(reg_req), .operating(operating));

/* verification/mdsl_master_model.sv */
// Mode 3 master model
`timescale 1ns/1ps
module mdsl_master_model (
  // Link pins
  output logic sel_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic [15:0] tx [40];
  logic [15:0] rx [40];
  initial begin
    sel_n = 1'b1;
    sck = 1'b1; // Idles high
    mosi = 1'b1;
  end
  task automatic frame(input int n, input int bits);
    sel_n = 1'b0; // One slave only
    #1000;
    for (int w = 0; w < n; w++) begin
      for (int b = 15; b >= (w == n - 1 ? 16 - bits : 0); b--) begin
        sck = 1'b0;
        mosi = tx[w][b];
        #400;
        sck = 1'b1; // 800 ns period
        rx[w][b] = miso;
        #400;
      end
    end
    sel_n = 1'b1;
    mosi = 1'b1; // Pull-up once released
    #1_000_000;
  endtask : frame
endmodule : mdsl_master_model

/* verification/mdsl_link_bench.sv */
// Self-checking bench for the link
`timescale 1ns/1ps
module mdsl_link_bench
  import mdsl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] status0 = 16'h0000;
  logic [15:0] status1 = 16'h0000;
  logic [15:0] reg_rdata = 16'h0000;
  logic sel_n, sck, mosi, miso_out, miso_oe, operating, frame_error;
  mdsl_reg_req_s reg_req;
  logic [31:0] wq[$];
  logic [7:0] a;
  logic [7:0] cmds [4] = '{MDSL_CMD_ACTIVATE, 8'h55, MDSL_CMD_DEACTIVATE, MDSL_CMD_LINK_CHECK};
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  // Pull-up holds the shared line when released
  mdsl_master_model m (.sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso_oe ? miso_out : 1'b1));
  mdsl_link dut (.clk_sys(clk_sys), .rst(rst), .spi_sel_n(sel_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso_out(miso_out), .spi_miso_oe(miso_oe), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .status0(status0), .status1(status1), .operating(operating), .frame_error(frame_error));
  function automatic logic [15:0] rdf(input logic [7:0] ad);
    return {ad, ~ad};
  endfunction : rdf
  always @(posedge clk_sys) begin
    if (reg_req.rd) reg_rdata <= rdf(reg_req.addr);
    if (reg_req.wr) wq.push_back({8'h00, reg_req.addr, reg_req.data});
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic run(input logic [7:0] cmd, input int nd, input int bits);
    @(posedge clk_sys);
    #5;
    status0 = 16'($urandom);
    status1 = 16'($urandom);
    wq.delete();
    m.tx[0] = {cmd, a};
    m.tx[1] = MDSL_RESERVED_HEADER_WORD;
    for (int k = 0; k < nd; k++) m.tx[k + 2] = cmd == MDSL_CMD_WRITE ? 16'($urandom) : 16'h0000;
    m.frame(nd + 2, bits);
    if (bits == 16) chk("status", {m.rx[0], m.rx[1]}, {status0, status1});
    $display("test %h done", cmd);
  endtask : run
  initial begin
    #9_500_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    int nd;
    void'($urandom(23980));
    repeat (10) @(posedge clk_sys);
    #5 rst = 1'b0;
    a = 8'($urandom) | 8'h01;
    run(MDSL_CMD_WRITE, 33, 16);
    chk("count", 32'(wq.size()), 32'h0000_0020);
    chk("overlong", 32'(frame_error), 32'h0000_0001);
    for (int k = 0; k < 32; k++) chk("wr", wq[k], {8'h00, 8'((a & 8'hFE) + 8'(2 * k)), m.tx[k + 2]});
    nd = 1 + int'($urandom % 8);
    a = 8'($urandom);
    run(MDSL_CMD_READ, nd, 16);
    chk("flag", 32'(frame_error), 32'h0000_0000);
    for (int k = 0; k < nd; k++) chk("rd", 32'(m.rx[k + 2]), 32'(rdf(8'((a & 8'hFE) + 8'(2 * k)))));
    for (int t = 0; t < 4; t++) begin
      run(cmds[t], 0, 16);
      chk("op", 32'(operating), 32'(t < 2));
      chk("quiet", 32'(wq.size()), 32'h0000_0000);
    end
    run(MDSL_CMD_ACTIVATE, -1, 5);
    run(MDSL_CMD_LINK_CHECK, 0, 16);
    chk("op", 32'(operating), 32'h0000_0000);
    final_report();
  end
endmodule : mdsl_link_bench
